// file: shared/irq_cfg_pkg.sv
// Constants, register map and carrier types for the interrupt status and hardware configuration block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package irq_cfg_pkg;
  localparam logic [11:0] addr_interrupt_status_c  = 12'h00c;
  localparam logic [11:0] addr_hardware_configuration_c   = 12'h010;
  localparam logic [11:0] addr_int_en_c   = 12'h014;
  localparam logic [11:0] addr_wake_sel_c = 12'h018;

  localparam int usb_bit_c     = 20;
  localparam int txoff_bit_c   = 19;
  localparam int rxoff_bit_c   = 18;
  localparam int phy_bit_c     = 17;
  localparam int dp_bit_c      = 16;
  localparam int macerr_bit_c  = 15;
  localparam int utxfp_bit_c   = 12;
  localparam int npins_c       = 12;

  localparam int clk125_bit_c  = 25;
  localparam int ref25_bit_c   = 24;
  localparam int detsts_bit_c  = 15;
  localparam int deten_bit_c   = 14;
  localparam int protect_bit_c = 12;

  localparam logic [31:0] sts_mask_c = 32'h001f_9fff;
  localparam logic [31:0] zero_c     = 32'h0000_0000;

  // Reference clock: 125 MHz divided by 5, high 2 then low 3
  localparam int clk_mhz_c      = 125;
  localparam int ref_mhz_c      = 25;
  localparam int ref_div_c      = clk_mhz_c / ref_mhz_c;
  localparam logic [2:0] ref_div_last_c = 3'(ref_div_c - 1);
  localparam logic [2:0] ref_high_c     = 3'(ref_div_c / 2);

  localparam logic [1:0] htrans_nonseq_c = 2'h2;

  typedef struct packed {
    logic        usb_event;
    logic        fifo_tx_off;
    logic        mac_transmit_register_off;
    logic        fifo_rx_off;
    logic        mac_receive_register_off;
    logic        ext_transceiver_irq_pin_n;
    logic        data_port_done;
    logic        mac_error_any;
    logic        usb_tx_frame_waiting;
    logic [11:0] pin_level;
  } event_src_t;

  typedef enum logic [2:0] {
    attached_s  = 3'b001,
    detached_s  = 3'b010,
    reattach_s  = 3'b100
  } attach_state_t;
endpackage

// file: design/irq_status_and_hw_config.sv
// Interrupt status, interrupt enable and hardware configuration registers on AHB-Lite
module irq_status_and_hw_config (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    por_n,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire irq_cfg_pkg::event_src_t src,
  input  wire logic                    phy_link_up,
  output logic [11:0]                  pin_wake_clear,
  output logic                         usb_detached,
  output logic                         internal_gig_clock_enable,
  output logic                         ref_clock_out_pin,
  output logic                         irq
);
  import irq_cfg_pkg::*;

  // ----------------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------------
  logic        wr_pend_ff;
  logic        rd_pend_ff;
  logic [11:0] addr_ff;
  logic        wr_sts;
  logic        wr_cfg;
  logic        wr_en;
  logic        wr_sel;
  logic        rd_sts;
  logic        take;

  assign take = hsel && hready && (htrans == htrans_nonseq_c);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 12'h000;
    end else begin
      wr_pend_ff <= take && hwrite;
      rd_pend_ff <= take && !hwrite;
      if (take) begin
        addr_ff <= haddr[11:0];
      end
    end
  end

  assign wr_sts = wr_pend_ff && (addr_ff == addr_interrupt_status_c);
  assign wr_cfg = wr_pend_ff && (addr_ff == addr_hardware_configuration_c);
  assign wr_en  = wr_pend_ff && (addr_ff == addr_int_en_c);
  assign wr_sel = wr_pend_ff && (addr_ff == addr_wake_sel_c);
  assign rd_sts = take && !hwrite && (haddr[11:0] == addr_interrupt_status_c);

  // Zero wait states: every transfer completes in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------------
  logic [31:0] level_now;
  logic [31:0] pulse_now;
  logic [31:0] sts_ff;
  logic [31:0] nxt_sts;
  logic [31:0] clr_mask;
  logic [31:0] int_en_ff;
  logic        pins_caught_ff;

  always_comb begin
    level_now                 = zero_c;
    pulse_now                 = zero_c;
    level_now[usb_bit_c]      = src.usb_event;
    level_now[txoff_bit_c]    = src.fifo_tx_off | src.mac_transmit_register_off;
    level_now[rxoff_bit_c]    = src.fifo_rx_off | src.mac_receive_register_off;
    level_now[phy_bit_c]      = !src.ext_transceiver_irq_pin_n;
    pulse_now[dp_bit_c]       = src.data_port_done;
    level_now[macerr_bit_c]   = src.mac_error_any;
    level_now[npins_c-1:0]    = src.pin_level;
  end

  // Read clears the sticky bits; a new event in the same cycle wins
  assign clr_mask = (rd_sts ? sts_mask_c : zero_c) | (wr_sts ? (hwdata & sts_mask_c) : zero_c);

  always_comb begin
    nxt_sts = ((sts_ff & ~clr_mask) | level_now | pulse_now) & sts_mask_c;
    nxt_sts[utxfp_bit_c] = src.usb_tx_frame_waiting;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_ff         <= zero_c;
      pins_caught_ff <= 1'b0;
    end else begin
      pins_caught_ff <= 1'b1;
      if (!pins_caught_ff) begin
        sts_ff                 <= zero_c;
        sts_ff[npins_c-1:0]    <= src.pin_level;
      end else begin
        sts_ff <= nxt_sts;
      end
    end
  end

  // Clearing a pin flag clears its wake event one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_wake_clear <= 12'h000;
    end else begin
      // Only flags that were really set clear a wake event
      pin_wake_clear <= clr_mask[npins_c-1:0] & sts_ff[npins_c-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_en_ff <= zero_c;
    end else if (wr_en) begin
      int_en_ff <= hwdata & sts_mask_c;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(nxt_sts & int_en_ff);
    end
  end

  // ----------------------------------------------------------------------------
  // Hardware configuration
  // ----------------------------------------------------------------------------
  // Protected fields live on the power-on reset only; hresetn is the lesser reset
  logic          clk125_ff;
  logic          ref25_ff;
  logic          protect_ff;
  logic          det_sts_ff;
  logic          det_en_ff;
  logic [11:0]   wake_sel_ff;
  attach_state_t state_ff;
  logic          reattach_evt;

  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      protect_ff <= 1'b0;
    end else if (wr_cfg) begin
      protect_ff <= hwdata[protect_bit_c];
    end
  end

  // Lesser reset clears the enables only while protection is off
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      clk125_ff <= 1'b0;
      ref25_ff  <= 1'b0;
    end else if (!hresetn && !protect_ff) begin
      clk125_ff <= 1'b0;
      ref25_ff  <= 1'b0;
    end else if (hresetn && wr_cfg) begin
      clk125_ff <= hwdata[clk125_bit_c];
      ref25_ff  <= hwdata[ref25_bit_c];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_gig_clock_enable <= 1'b0;
    end else begin
      internal_gig_clock_enable <= clk125_ff;
    end
  end

  // Reference clock divider; stops low when disabled
  logic [2:0] ref_cnt_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt_ff        <= 3'h0;
      ref_clock_out_pin <= 1'b0;
    end else if (!ref25_ff) begin
      ref_cnt_ff        <= 3'h0;
      ref_clock_out_pin <= 1'b0;
    end else begin
      ref_cnt_ff        <= (ref_cnt_ff == ref_div_last_c) ? 3'h0 : ref_cnt_ff + 3'h1;
      ref_clock_out_pin <= (ref_cnt_ff < ref_high_c);
    end
  end

  // ----------------------------------------------------------------------------
  // Cable detach
  // ----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_sel_ff <= 12'h000;
    end else if (wr_sel) begin
      wake_sel_ff <= hwdata[npins_c-1:0];
    end
  end

  assign reattach_evt = phy_link_up || |(src.pin_level & wake_sel_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= attached_s;
    end else begin
      case (state_ff)
        attached_s: begin
          if (wr_cfg && hwdata[deten_bit_c]) begin
            state_ff <= detached_s;
          end
        end
        detached_s: begin
          if (reattach_evt) begin
            state_ff <= reattach_s;
          end
        end
        reattach_s: state_ff <= attached_s;
        default:    state_ff <= attached_s;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      det_en_ff    <= 1'b0;
      usb_detached <= 1'b0;
    end else begin
      usb_detached <= (state_ff == detached_s) || (state_ff == attached_s && wr_cfg && hwdata[deten_bit_c]);
      if (state_ff == reattach_s) begin
        det_en_ff <= 1'b0;
      end else if (state_ff == attached_s && wr_cfg && hwdata[deten_bit_c]) begin
        det_en_ff <= 1'b1;
      end
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      det_sts_ff <= 1'b0;
    end else if (state_ff == reattach_s) begin
      det_sts_ff <= 1'b1;
    end else if (wr_cfg && hwdata[detsts_bit_c]) begin
      det_sts_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------------
  logic [31:0] cfg_view;

  always_comb begin
    cfg_view                = zero_c;
    cfg_view[clk125_bit_c]  = clk125_ff;
    cfg_view[ref25_bit_c]   = ref25_ff;
    cfg_view[detsts_bit_c]  = det_sts_ff;
    cfg_view[deten_bit_c]   = det_en_ff;
    cfg_view[protect_bit_c] = protect_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= zero_c;
    end else if (take && !hwrite) begin
      case (haddr[11:0])
        addr_interrupt_status_c:  hrdata <= sts_ff;
        addr_hardware_configuration_c:   hrdata <= cfg_view;
        addr_int_en_c:   hrdata <= int_en_ff;
        addr_wake_sel_c: hrdata <= {20'h00000, wake_sel_ff};
        default:         hrdata <= zero_c;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  a_usb_level_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff && src.usb_event |=> sts_ff[usb_bit_c]) else $error("usb flag not set");
  a_tx_off_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff && src.mac_transmit_register_off |=> sts_ff[txoff_bit_c]) else $error("tx off flag not set");
  a_rx_off_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff && src.fifo_rx_off |=> sts_ff[rxoff_bit_c]) else $error("rx off flag not set");
  a_phy_pin_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff && !src.ext_transceiver_irq_pin_n |=> sts_ff[phy_bit_c]) else $error("phy flag not set");
  a_dp_pulse_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff && src.data_port_done ##1 !rd_sts && !wr_sts |=> sts_ff[dp_bit_c])
    else $error("data port flag lost");
  a_frame_wait_track: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff |=> sts_ff[utxfp_bit_c] == $past(src.usb_tx_frame_waiting)) else $error("frame pending wrong");
  a_wake_clear_pair: assert property (@(posedge hclk) disable iff (!hresetn)
    clr_mask[0] && sts_ff[0] |=> pin_wake_clear[0]) else $error("wake clear missing");
  a_ref_clk_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !ref25_ff ##1 !ref25_ff |-> !ref_clock_out_pin) else $error("ref clock runs when off");
  a_detach_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == attached_s && wr_cfg && hwdata[deten_bit_c] |=> usb_detached) else $error("no detach");
  a_reattach_done: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == detached_s && reattach_evt |=> ##1 !det_en_ff && det_sts_ff) else $error("reattach incomplete");
  a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    irq |-> $past(|(nxt_sts & int_en_ff))) else $error("irq without cause");

  // ----------------------------------------------------------------------------
  // Status source, interrupt and bus response assertions
  // ----------------------------------------------------------------------------
  a_fifo_tx_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff && src.fifo_tx_off |=> sts_ff[txoff_bit_c]) else $error("fifo tx off flag not set");
  a_mac_receive_register_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff && src.mac_receive_register_off |=> sts_ff[rxoff_bit_c]) else $error("mac_receive_register off flag not set");
  a_dp_pulse_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff && src.data_port_done |=> sts_ff[dp_bit_c]) else $error("data port flag not set");
  a_mac_err_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff && src.mac_error_any |=> sts_ff[macerr_bit_c]) else $error("mac error flag not set");
  a_pin_flag_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff && (|src.pin_level) |=> (|sts_ff[npins_c-1:0])) else $error("pin flag not set");
  a_level_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff && sts_ff[usb_bit_c] && !clr_mask[usb_bit_c] |=> sts_ff[usb_bit_c])
    else $error("usb flag dropped");
  a_pulse_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_caught_ff && rd_sts && !src.data_port_done |=> !sts_ff[dp_bit_c]) else $error("data port flag kept");
  a_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    int_en_ff == zero_c |=> !irq) else $error("irq while all masked");
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp) else $error("bus response not okay");

  // ----------------------------------------------------------------------------
  // Configuration assertions
  // ----------------------------------------------------------------------------
  a_gig_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> internal_gig_clock_enable == $past(clk125_ff)) else $error("gig clock enable stale");
  a_ref_high_phase: assert property (@(posedge hclk) disable iff (!hresetn)
    ref25_ff && ref_cnt_ff < ref_high_c |=> ref_clock_out_pin) else $error("ref clock high phase short");
  a_ref_low_phase: assert property (@(posedge hclk) disable iff (!hresetn)
    ref25_ff && ref_cnt_ff >= ref_high_c |=> !ref_clock_out_pin) else $error("ref clock low phase short");
  // Watched on the power-on reset, since the lesser reset is the event itself
  a_protect_keeps: assert property (@(posedge hclk) disable iff (!por_n)
    !hresetn && protect_ff |=> clk125_ff == $past(clk125_ff) && ref25_ff == $past(ref25_ff))
    else $error("protected field changed");
  a_unprot_clears: assert property (@(posedge hclk) disable iff (!por_n)
    !hresetn && !protect_ff |=> !clk125_ff && !ref25_ff) else $error("unprotected field kept");

  // ----------------------------------------------------------------------------
  // Detach assertions
  // ----------------------------------------------------------------------------
  a_detach_stays: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == detached_s && !reattach_evt |=> usb_detached) else $error("left detach without event");
  a_det_sts_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == reattach_s |=> det_sts_ff) else $error("detach status not set");
  a_det_sts_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff != reattach_s && wr_cfg && hwdata[detsts_bit_c] |=> !det_sts_ff) else $error("detach status kept");

  // ----------------------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------------------

  c_detach_cycle: cover property (@(posedge hclk) disable iff (!hresetn)
    state_ff == detached_s ##[1:50] state_ff == reattach_s);
  c_irq_raised: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
  c_read_clear: cover property (@(posedge hclk) disable iff (!hresetn) rd_sts && |sts_ff);
  c_ref_clock_runs: cover property (@(posedge hclk) disable iff (!hresetn) $rose(ref_clock_out_pin));
  c_wake_pulse: cover property (@(posedge hclk) disable iff (!hresetn) |pin_wake_clear);
endmodule

// file: tb/event_source_model.sv
// Model of the event sources and external transceiver that feed the status block
module event_source_model (
  input  wire logic                    hclk,
  input  wire logic [20:0]             active,
  output irq_cfg_pkg::event_src_t      src
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_cfg_pkg::*;
  logic dp_ff;

  always_ff @(posedge hclk) begin
    dp_ff <= active[14];
  end
  // Transceiver holds its pin low until it clears its own source
  assign src = {active[20:16], ~active[15],
                active[14] & ~dp_ff,
                active[13:0]};
endmodule

// file: tb/irq_status_and_hw_config_test.sv
// Self-checking testbench for the interrupt status and hardware configuration block
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module irq_status_and_hw_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_cfg_pkg::*;
  logic hclk, hresetn, por_n, hsel, hwrite, hready, hreadyout, hresp, phy_link_up;
  logic usb_detached, gig_en, ref_pin, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] pin_wake_clear, wake_seen;
  logic [20:0] act;
  event_src_t src;
  int n_fail = 0;
  int checked = 0;

  assign hready = hreadyout;
  event_source_model i_src (.hclk(hclk), .active(act), .src(src));
  irq_status_and_hw_config i_dut (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src(src), .phy_link_up(phy_link_up),
    .pin_wake_clear(pin_wake_clear), .usb_detached(usb_detached),
    .internal_gig_clock_enable(gig_en), .ref_clock_out_pin(ref_pin), .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) wake_seen <= wake_seen | pin_wake_clear;

  // ----------------------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------------------
  task automatic cycles(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= htrans_nonseq_c; haddr <= {20'h00000, a}; hwrite <= w; hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, rd);
    `CHK(rd, e)
  endtask
  task automatic lite_reset(input logic por);
    @(posedge hclk);
    hresetn <= 1'b0; por_n <= ~por;
    cycles(5);
    hresetn <= 1'b1; por_n <= 1'b1;
  endtask
  task automatic pulse_dp;
    act[14] <= 1'b1;
    @(posedge hclk);
    act[14] <= 1'b0;
  endtask
  task automatic count_ref(output logic [3:0] c);
    c = 4'h0;
    repeat (10) begin @(posedge hclk); #1; c = c + 4'(ref_pin); end
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset;
    rchk(addr_hardware_configuration_c, zero_c);
    rchk(addr_interrupt_status_c, 32'h0000_00a5);
    act[11:0] <= 12'h000;
    cycles(2);
    rchk(addr_interrupt_status_c, 32'h0000_00a5);
    rchk(addr_interrupt_status_c, zero_c);
  endtask
  task automatic t_levels;
    int sb[9] = '{20, 19, 18, 17, 16, 15, 13, 12, 5};
    int st[9] = '{20, 19, 19, 18, 18, 17, 15, 12, 5};
    for (int i = 0; i < 9; i++) begin
      act[sb[i]] <= 1'b1;
      cycles(2);
      rchk(addr_interrupt_status_c, 32'h1 << st[i]);
      rchk(addr_interrupt_status_c, 32'h1 << st[i]);
      act <= 21'h000000;
      cycles(2);
      bus(1'b0, addr_interrupt_status_c, zero_c, rd);
      rchk(addr_interrupt_status_c, zero_c);
    end
  endtask
  task automatic t_pulse;
    pulse_dp();
    cycles(2);
    rchk(addr_interrupt_status_c, 32'h0001_0000);
    rchk(addr_interrupt_status_c, zero_c);
    pulse_dp();
    cycles(2);
    wr(addr_interrupt_status_c, 32'h0001_0000);
    rchk(addr_interrupt_status_c, zero_c);
  endtask
  task automatic t_irq;
    wr(addr_int_en_c, 32'h0001_0000);
    pulse_dp();
    cycles(3);
    `CHK(irq, 1'b1)
    bus(1'b0, addr_interrupt_status_c, zero_c, rd);
    cycles(3);
    `CHK(irq, 1'b0)
    wr(addr_int_en_c, zero_c);
    pulse_dp();
    cycles(3);
    `CHK(irq, 1'b0)
    bus(1'b0, addr_interrupt_status_c, zero_c, rd);
  endtask
  task automatic t_cfg;
    logic [3:0] c;
    wr(addr_hardware_configuration_c, 32'h0300_0000);
    rchk(addr_hardware_configuration_c, 32'h0300_0000);
    `CHK(gig_en, 1'b1)
    count_ref(c);
    `CHK(c, 4'h4)
    wr(addr_hardware_configuration_c, zero_c);
    count_ref(c);
    `CHK(c, 4'h0)
    `CHK(gig_en, 1'b0)
  endtask
  task automatic t_protect;
    wr(addr_hardware_configuration_c, 32'h0300_1000);
    lite_reset(1'b0);
    rchk(addr_hardware_configuration_c, 32'h0300_1000);
    wr(addr_hardware_configuration_c, 32'h0300_0000);
    lite_reset(1'b0);
    rchk(addr_hardware_configuration_c, zero_c);
  endtask
  task automatic t_detach;
    wr(addr_hardware_configuration_c, 32'h0000_4000);
    cycles(6);
    `CHK(usb_detached, 1'b1)
    phy_link_up <= 1'b1;
    cycles(4);
    `CHK(usb_detached, 1'b0)
    phy_link_up <= 1'b0;
    rchk(addr_hardware_configuration_c, 32'h0000_8000);
    wr(addr_hardware_configuration_c, 32'h0000_8000);
    rchk(addr_hardware_configuration_c, zero_c);
    wr(addr_wake_sel_c, 32'h0000_0008);
    wr(addr_hardware_configuration_c, 32'h0000_4000);
    cycles(2);
    act[3] <= 1'b1;
    cycles(4);
    `CHK(usb_detached, 1'b0)
    act[3] <= 1'b0;
    // Off the edge, so the collector cannot race this clear
    #1;
    wake_seen = 12'h000;
    rchk(addr_interrupt_status_c, 32'h0000_0008);
    cycles(2);
    `CHK(wake_seen, 12'h008)
    rchk(addr_hardware_configuration_c, 32'h0000_8000);
  endtask

  // ----------------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------------------
  task automatic test_done;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #160000;
    n_fail++;
    test_done();
  end
  initial begin
    {hresetn, por_n, hsel, hwrite, phy_link_up} = 5'h00;
    haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hsize = 3'h2; wake_seen = 12'h000;
    act = 21'h0000a5;
    cycles(5);
    hresetn <= 1'b1; por_n <= 1'b1;
    t_reset();
    t_levels();
    t_pulse();
    t_irq();
    t_cfg();
    t_protect();
    t_detach();
    test_done();
  end
endmodule
